// *** verilog/lsif_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Receive lock-lost is raised when recovered and reference clocks differ by over 100 ppm.
// - The receive lock-lost output is high while lock is lost.
// - The receive signal-lost output is high while the signal is lost.
// - An enabled transmit error drives the channel's transmit fault interrupt low.
// - A host read of the status register clears a pending transmit fault.
// - A phase-initialization pulse clears a transmit fault that the FIFO error caused.
// - A high-to-low change of transmit lock-lost clears a pending transmit fault.
// - After reset only transmit lock loss is an enabled transmit fault source.
// - The receive fault interrupt output is never used and stays inactive.
// - A low power-on reset input holds the block in reset.
// - The reference frequency select is sampled only at reset release.
module lsif_top #(
   parameter int NCH    = lsif_pkg::NUM_CH,
   parameter int WINDOW = lsif_pkg::REF_WINDOW
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             power_on_reset_n,
   input  wire logic             ref_clock_in_pos,
   input  wire logic             ref_clock_in_neg,
   input  wire logic [1:0]       ref_freq_select,
   input  wire logic [NCH-1:0]   rec_clock_tick,
   input  wire logic [NCH-1:0]   rx_signal_lost_in,
   input  wire logic [NCH-1:0]   tx_lock_lost_bit,
   input  wire logic [NCH-1:0]   fifo_error_flag,
   input  wire logic [NCH-1:0]   fifo_phase_init,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [31:0]      wb_dat_i,
   input  wire logic [3:0]       wb_sel_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   output logic                  wb_err_o,
   output logic      [NCH-1:0]   rx_signal_lost_out,
   output logic      [NCH-1:0]   rx_lock_lost_out,
   output logic      [NCH-1:0]   tx_fault_irq_n,
   output logic      [NCH-1:0]   rx_fault_irq_n,
   output logic                  irq
);
   initial begin
      if (NCH < 1 || NCH > 2)
         $error("lsif_top: one or two channels supported");
   end

   localparam int SW = 8;

   // Both resets act together; the pin reset is taken as synchronous.
   logic rst;
   assign rst = srst | ~power_on_reset_n;

   // Reference tick from the positive input rising edge.
   logic ref_q_ff, nxt_ref_q;
   logic ref_tick;
   assign nxt_ref_q = ref_clock_in_pos;
   assign ref_tick = ref_clock_in_pos & ~ref_q_ff;

   logic [NCH-1:0] lol;
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_mon
         lsif_lock_mon #(
            .WINDOW (WINDOW),
            .PPM    (lsif_pkg::LOCK_PPM_LIMIT)
         ) u_mon (
            .clk       (clk),
            .srst      (rst),
            .ref_tick  (ref_tick),
            .rec_tick  (rec_clock_tick[g]),
            .lock_lost (lol[g])
         );
      end
   endgenerate

   // Register state.
   logic [1:0]     refsel_ff, nxt_refsel;
   logic           in_rst_ff, nxt_in_rst;
   logic [SW-1:0]  stat_ff, nxt_stat;
   logic [SW-1:0]  mask_ff, nxt_mask;
   logic [1:0]     txen_ff [NCH], nxt_txen [NCH];
   logic [NCH-1:0] txf_ff, nxt_txf;
   logic [NCH-1:0] txf_n_ff;
   logic [NCH-1:0] fcause_ff, nxt_fcause;
   logic [NCH-1:0] tx_lock_lost_bit_q_ff, nxt_tx_lock_lost_bit_q;
   logic [NCH-1:0] los_ff, lol_ff, nxt_los, nxt_lol;
   logic [31:0]    dat_ff, nxt_dat;
   logic           ack_ff, nxt_ack, err_ff, nxt_err, irq_ff, nxt_irq;

   logic req, wr, rd, hit;
   logic [31:0] rdata;
   logic [SW-1:0] wmask, ev;
   assign req = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
   assign wr = req & wb_we_i;
   assign rd = req & ~wb_we_i;
   assign wmask = wb_sel_i[0] ? wb_dat_i[SW-1:0] : '0;

   always_comb begin
      hit = 1'b1;
      rdata = '0;
      unique case (wb_adr_i)
         lsif_pkg::STATUS_OFFS: rdata[SW-1:0] = stat_ff;
         lsif_pkg::MASK_OFFS:   rdata[SW-1:0] = mask_ff;
         lsif_pkg::TXSTAT_OFFS: rdata[NCH-1:0] = txf_ff;
         lsif_pkg::TXEN_OFFS: begin
            for (int c = 0; c < NCH; c++)
               rdata[c*lsif_pkg::CH_STRIDE +: 2] = txen_ff[c];
         end
         lsif_pkg::REFSEL_OFFS: rdata[1:0] = refsel_ff;
         default: hit = 1'b0;
      endcase
   end

   always_comb begin
      nxt_in_rst = 1'b0;
      // Select is caught only in the first cycle after reset release.
      nxt_refsel = in_rst_ff ? ref_freq_select : refsel_ff;
      nxt_mask = mask_ff;
      nxt_txf = txf_ff;
      nxt_fcause = fcause_ff;
      nxt_tx_lock_lost_bit_q = tx_lock_lost_bit;
      nxt_los = rx_signal_lost_in;
      nxt_lol = lol;
      ev = '0;
      for (int c = 0; c < NCH; c++) begin
         nxt_txen[c] = txen_ff[c];
         if (wr && hit && wb_adr_i == lsif_pkg::TXEN_OFFS && wb_sel_i[0])
            nxt_txen[c] = wb_dat_i[c*lsif_pkg::CH_STRIDE +: 2];
      end
      for (int c = 0; c < NCH; c++) begin
         // Clears first, so that a same-cycle event sets again.
         if (rd && wb_adr_i == lsif_pkg::STATUS_OFFS)
            nxt_txf[c] = 1'b0;
         if (fifo_phase_init[c] && fcause_ff[c]) begin
            nxt_txf[c] = 1'b0;
            nxt_fcause[c] = 1'b0;
         end
         if (tx_lock_lost_bit_q_ff[c] && !tx_lock_lost_bit[c])
            nxt_txf[c] = 1'b0;
         // Fault holds until cleared even if the FIFO error goes; a falling lock-lost clears it.
         if (txen_ff[c][lsif_pkg::SRC_TX_LOCK_LOST_BIT] && tx_lock_lost_bit[c]
             && !tx_lock_lost_bit_q_ff[c]) begin
            nxt_txf[c] = 1'b1;
         end
         if (txen_ff[c][lsif_pkg::SRC_FIERR] && fifo_error_flag[c]
             && !fifo_phase_init[c]) begin
            nxt_txf[c] = 1'b1;
            nxt_fcause[c] = 1'b1;
         end
         ev[c*lsif_pkg::CH_STRIDE + lsif_pkg::LOS_BIT] =
            rx_signal_lost_in[c] & ~los_ff[c];
         ev[c*lsif_pkg::CH_STRIDE + lsif_pkg::LOL_BIT] = lol[c] & ~lol_ff[c];
         ev[c*lsif_pkg::CH_STRIDE + lsif_pkg::TXF_BIT] = nxt_txf[c] & ~txf_ff[c];
      end
      nxt_stat = stat_ff;
      if (wr && wb_adr_i == lsif_pkg::STATUS_OFFS)
         nxt_stat = stat_ff & ~wmask;
      if (wr && wb_adr_i == lsif_pkg::MASK_OFFS && wb_sel_i[0])
         nxt_mask = wb_dat_i[SW-1:0];
      nxt_stat = nxt_stat | ev;
      nxt_irq = |(nxt_stat & nxt_mask);
      nxt_ack = req & hit;
      nxt_err = req & ~hit;
      nxt_dat = (rd && hit) ? rdata : '0;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         in_rst_ff <= 1'b1;
         refsel_ff <= '0;
         ref_q_ff <= 1'b0;
         stat_ff <= '0;
         mask_ff <= lsif_pkg::MASK_RESET;
         for (int c = 0; c < NCH; c++)
            txen_ff[c] <= lsif_pkg::TXEN_RESET;
         txf_ff <= '0;
         txf_n_ff <= '1;
         fcause_ff <= '0;
         tx_lock_lost_bit_q_ff <= '0;
         los_ff <= '0;
         lol_ff <= '0;
         dat_ff <= '0;
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         in_rst_ff <= nxt_in_rst;
         refsel_ff <= nxt_refsel;
         ref_q_ff <= nxt_ref_q;
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         txen_ff <= nxt_txen;
         txf_ff <= nxt_txf;
         // Kept as its own flop so the pin needs no gate after the register.
         txf_n_ff <= ~nxt_txf;
         fcause_ff <= nxt_fcause;
         tx_lock_lost_bit_q_ff <= nxt_tx_lock_lost_bit_q;
         los_ff <= nxt_los;
         lol_ff <= nxt_lol;
         dat_ff <= nxt_dat;
         ack_ff <= nxt_ack;
         err_ff <= nxt_err;
         irq_ff <= nxt_irq;
      end
   end

   // The negative reference input only matters to the analog receiver.
   logic unused_neg;
   assign unused_neg = ref_clock_in_neg;

   logic [NCH-1:0] rxf_ff;
   always_ff @(posedge clk) begin
      rxf_ff <= '1;
   end

   assign wb_dat_o = dat_ff;
   assign wb_ack_o = ack_ff;
   assign wb_err_o = err_ff;
   assign rx_signal_lost_out = los_ff;
   assign rx_lock_lost_out = lol_ff;
   assign tx_fault_irq_n = txf_n_ff;
   assign rx_fault_irq_n = rxf_ff;
   assign irq = irq_ff;
endmodule

// *** verilog/lsif_pkg.sv ***
package lsif_pkg;
   localparam int NUM_CH = 2;
   localparam int LOCK_PPM_LIMIT = 100;
   localparam int PPM_SCALE = 1000000;
   localparam int CLK_MHZ = 10;
   localparam int CNT_W = 24;
   // Reference edges counted per comparison window.
   localparam int REF_WINDOW = 100000;

   // Register byte offsets.
   localparam logic [7:0] STATUS_OFFS = 8'h00;
   localparam logic [7:0] MASK_OFFS = 8'h04;
   localparam logic [7:0] TXSTAT_OFFS = 8'h08;
   localparam logic [7:0] TXEN_OFFS = 8'h0c;
   localparam logic [7:0] REFSEL_OFFS = 8'h10;

   // Per-channel bit positions in STATUS and MASK.
   localparam int LOS_BIT = 0;
   localparam int LOL_BIT = 1;
   localparam int TXF_BIT = 2;
   localparam int CH_STRIDE = 4;

   // Transmit error source enable bits; after reset only the lock loss one.
   localparam int SRC_TX_LOCK_LOST_BIT = 0;
   localparam int SRC_FIERR = 1;
   localparam logic [1:0] TXEN_RESET = 2'h1;
   localparam logic [7:0] MASK_RESET = 8'h00;
endpackage

// *** verilog/lsif_lock_mon.sv ***
`timescale 1ns/1ps
// Compares recovered-clock edge count with reference-clock edge count.
module lsif_lock_mon #(
   parameter int WINDOW = lsif_pkg::REF_WINDOW,
   parameter int PPM    = lsif_pkg::LOCK_PPM_LIMIT
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic ref_tick,
   input  wire logic rec_tick,
   output logic      lock_lost
);
   localparam int TOL = (WINDOW * PPM) / lsif_pkg::PPM_SCALE;
   localparam int W = lsif_pkg::CNT_W;
   initial begin
      if (WINDOW < 1 || WINDOW >= (1 << (W - 1)) || TOL < 1)
         $error("lsif_lock_mon: window too small or too large");
   end
   logic [W-1:0] ref_cnt_ff, rec_cnt_ff, nxt_ref_cnt, nxt_rec_cnt;
   logic         lost_ff, nxt_lost;
   logic [W-1:0] diff;
   logic [W-1:0] rec_tot;
   always_comb begin
      nxt_ref_cnt = ref_cnt_ff;
      nxt_rec_cnt = rec_cnt_ff;
      nxt_lost = lost_ff;
      // The closing cycle's recovered edge belongs to this window, so both
      // counts cover the same span and the first window is not short by one.
      rec_tot = rec_cnt_ff + W'(rec_tick);
      diff = (rec_tot > W'(WINDOW)) ? rec_tot - W'(WINDOW)
                                    : W'(WINDOW) - rec_tot;
      if (ref_tick && ref_cnt_ff == W'(WINDOW - 1)) begin
         // Window over: deviation beyond the ppm limit flags loss of lock.
         nxt_lost = diff > W'(TOL);
         nxt_ref_cnt = '0;
         nxt_rec_cnt = '0;
      end else begin
         if (ref_tick)
            nxt_ref_cnt = ref_cnt_ff + W'(1);
         if (rec_tick && rec_cnt_ff != '1)
            nxt_rec_cnt = rec_cnt_ff + W'(1);
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         ref_cnt_ff <= '0;
         rec_cnt_ff <= '0;
         lost_ff <= 1'b0;
      end else begin
         ref_cnt_ff <= nxt_ref_cnt;
         rec_cnt_ff <= nxt_rec_cnt;
         lost_ff <= nxt_lost;
      end
   end
   assign lock_lost = lost_ff;
endmodule

// *** bench/lsif_far_model.sv ***
`timescale 1ns/1ps
module lsif_far_model (
   input  wire logic       clk,
   input  wire logic       srst,
   output logic            ref_clk,
   output logic [1:0]      rec_tick
);
   logic [6:0] cnt_ff;
   // Single-ended reference on the positive input, one edge per two cycles.
   always_ff @(posedge clk) begin
      if (srst) begin
         ref_clk <= 1'b0;
         cnt_ff <= 7'h0;
      end else begin
         ref_clk <= ~ref_clk;
         cnt_ff <= (cnt_ff == 7'h63) ? 7'h0 : cnt_ff + 7'h1;
      end
   end
   // Channel 1 loses one edge in fifty, far past the lock tolerance.
   assign rec_tick = {ref_clk && cnt_ff != 7'h1, ref_clk};
endmodule

// *** bench/lsif_asserts.sv ***
`timescale 1ns/1ps
module lsif_asserts #(
   parameter int NCH = 2
) (
   input wire logic           clk,
   input wire logic           srst,
   input wire logic           power_on_reset_n,
   input wire logic [NCH-1:0] rx_signal_lost_in,
   input wire logic [NCH-1:0] tx_lock_lost_bit,
   input wire logic [NCH-1:0] fifo_error_flag,
   input wire logic [NCH-1:0] fifo_phase_init,
   input wire logic           wb_cyc_i,
   input wire logic           wb_stb_i,
   input wire logic [7:0]     wb_adr_i,
   input wire logic [31:0]    wb_dat_o,
   input wire logic           wb_ack_o,
   input wire logic           wb_err_o,
   input wire logic [NCH-1:0] rx_signal_lost_out,
   input wire logic [NCH-1:0] tx_fault_irq_n,
   input wire logic [NCH-1:0] rx_fault_irq_n,
   input wire logic           irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst || !power_on_reset_n);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   sequence s_ans;
      (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
   endsequence
   AST_ANSWER: assert property (s_req |=> s_ans)
      else $error("bus answer missing or too long");
   AST_UNMAPPED: assert property (s_req and wb_adr_i > 8'h10 |=> wb_err_o)
      else $error("unmapped access not refused");
   AST_DATZ: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   AST_RXLOS: assert property (rx_signal_lost_out == $past(rx_signal_lost_in))
      else $error("signal lost flag wrong");
   AST_RXFLT: assert property (rx_fault_irq_n == {NCH{1'b1}})
      else $error("receive fault output used");
   AST_TXSET: assert property ($rose(tx_lock_lost_bit[0]) |-> ##[1:2] !tx_fault_irq_n[0])
      else $error("tx fault not raised");
   AST_TXHOLD: assert property (!tx_fault_irq_n[0] && !$fell(tx_lock_lost_bit[0])
      && !fifo_phase_init[0] && !$past(fifo_phase_init[0]) && !wb_cyc_i
      |=> !tx_fault_irq_n[0])
      else $error("tx fault dropped early");
   AST_TXCLR: assert property ($fell(tx_lock_lost_bit[0]) && !fifo_error_flag[0]
      |-> ##[1:2] tx_fault_irq_n[0])
      else $error("tx fault not cleared");
   AST_POR: assert property (disable iff (srst) !power_on_reset_n
      |=> tx_fault_irq_n == {NCH{1'b1}} && !irq)
      else $error("pin reset ignored");
endmodule
bind lsif_top lsif_asserts #(.NCH(NCH)) u_chk (.*);

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
   logic        clk = 0, srst = 1, por_n = 1, cyc = 0, stb = 0, we = 0;
   logic [1:0]  sel_r = 2'h2, los = 0, txl = 0, fer = 0, fpi = 0, rec;
   logic [1:0]  los_o, lol_o, txf_n, rxf_n;
   logic [7:0]  adr = 0;
   logic [31:0] dat = 0, dat_o, q;
   logic        ack, err, irq, e, ref_clk;
   int          n_errors = 0, checks = 0;
   always #50 clk = ~clk;
   lsif_far_model u_far (.clk(clk), .srst(srst), .ref_clk(ref_clk),
      .rec_tick(rec));
   lsif_top #(.WINDOW(10000)) DUT (.clk(clk), .srst(srst),
      .power_on_reset_n(por_n), .ref_clock_in_pos(ref_clk),
      .ref_clock_in_neg(1'b0), .ref_freq_select(sel_r),
      .rec_clock_tick(rec), .rx_signal_lost_in(los),
      .tx_lock_lost_bit(txl), .fifo_error_flag(fer),
      .fifo_phase_init(fpi), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .wb_err_o(err), .rx_signal_lost_out(los_o),
      .rx_lock_lost_out(lol_o), .tx_fault_irq_n(txf_n),
      .rx_fault_irq_n(rxf_n), .irq(irq));
   task automatic close_out();
      if (n_errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Outputs are read just after an edge, so they show pre-edge values.
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int i;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         if (ack === 1'b1 || err === 1'b1) break;
      end
      q = dat_o;
      e = err;
      if (i == 16) begin
         n_errors++;
         close_out();
      end else begin
         cyc <= 1'b0;
         stb <= 1'b0;
         we <= 1'b0;
      end
   endtask
   initial begin
      tick(16);
      srst <= 1'b0;
      tick(2);
      chk(32'({txf_n, rxf_n, irq}), 32'h1e);
      wb(0, lsif_pkg::TXEN_OFFS, 0);
      chk(q, 32'h11);
      sel_r <= 2'h1;
      wb(0, lsif_pkg::REFSEL_OFFS, 0);
      chk(q, 32'h2);
      por_n <= 1'b0;
      tick(2);
      por_n <= 1'b1;
      tick(2);
      wb(0, lsif_pkg::REFSEL_OFFS, 0);
      chk(q, 32'h1);
      wb(0, 8'h20, 0);
      chk(32'(e), 32'h1);
      los <= 2'h1;
      tick(3);
      chk(32'({los_o, irq}), 32'h2);
      wb(1, lsif_pkg::MASK_OFFS, 32'h1);
      tick(2);
      chk(32'(irq), 32'h1);
      wb(1, lsif_pkg::STATUS_OFFS, 32'h1);
      tick(2);
      chk(32'(irq), 32'h0);
      fer <= 2'h1;
      tick(4);
      chk(32'(txf_n), 32'h3);
      txl <= 2'h1;
      tick(3);
      chk(32'(txf_n), 32'h2);
      wb(0, lsif_pkg::STATUS_OFFS, 0);
      tick(2);
      chk(32'(txf_n), 32'h3);
      txl <= 2'h0;
      fer <= 2'h0;
      tick(2);
      txl <= 2'h1;
      tick(3);
      txl <= 2'h0;
      tick(3);
      chk(32'(txf_n), 32'h3);
      wb(1, lsif_pkg::TXEN_OFFS, 32'h13);
      fer <= 2'h1;
      tick(3);
      fer <= 2'h0;
      tick(8);
      chk(32'(txf_n), 32'h2);
      fpi <= 2'h1;
      tick(1);
      fpi <= 2'h0;
      tick(3);
      chk(32'(txf_n), 32'h3);
      wb(0, lsif_pkg::TXSTAT_OFFS, 0);
      chk(q, 32'h0);
      tick(45000);
      chk(32'(lol_o[0]), 32'h0);
      chk(32'(lol_o[1]), 32'h1);
      close_out();
   end
endmodule
